// File: bench/mcs_master_model.sv
/* rtu master model driving checked frame bytes.
   assumes crc is judged upstream and shown on rx_crc_ok_out. */
`timescale 1ns/1ps
module mcs_master_model (
	// clock
	input  wire       core_clk_in,
	// frame bytes to the slave
	output reg  [7:0] rx_data_out = 8'h5a,
	output reg        rx_valid_out = 1'b0,
	output reg        rx_end_out = 1'b0,
	output reg        rx_crc_ok_out = 1'b0
);
	integer i;
	task frame(input [87:0] f, input integer n, input c);
		begin
			for (i = 0; i < n; i = i + 1) begin
				@(negedge core_clk_in);
				rx_data_out = f[87-8*i -: 8];
				rx_valid_out = 1'b1;
			end
			@(negedge core_clk_in);
			rx_valid_out = 1'b0;
			rx_data_out = ~rx_data_out;
			rx_end_out = 1'b1;
			rx_crc_ok_out = c;
			@(negedge core_clk_in);
			rx_end_out = 1'b0;
			rx_crc_ok_out = ~c;
		end
	endtask
	task send06(input [7:0] a, input [15:0] r, input [15:0] v, input c);
		frame({a, 8'h06, r, v, 40'h0}, 6, c);
	endtask
	task send10(input [15:0] r, input [31:0] d);
		frame({8'h01, 8'h10, r, 16'h0002, 8'h04, d}, 11, 1'b1);
	endtask
endmodule

// File: bench/mcs_slave_assertions.sv
/* checks of the motion command register slave.
   assumes a bind to mcs_slave; sees only its ports. */
`timescale 1ns/1ps
module mcs_slave_assertions (
	// clock, reset, inputs
	input wire        core_clk_in,
	input wire        rst_in,
	input wire        rx_end_in,
	input wire        rx_crc_ok_in,
	input wire        decel_done_in,
	input wire        home_done_in,
	// outputs watched
	input wire        reply_ok_out,
	input wire        excite_out,
	input wire [2:0]  motion_state_out,
	input wire [31:0] run_speed_out,
	input wire [5:0]  data_select_out,
	input wire [15:0] motion_command_word_out,
	input wire [31:0] speed_of_data_one_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	wire [2:0]  st = motion_state_out;
	wire [15:0] w = motion_command_word_out;
	reply_after_end_a:
	assert property (reply_ok_out |-> $past(rx_end_in) && $past(rx_crc_ok_in))
		else $error("reply without good frame end");
	excite_copy_a:
	assert property (excite_out == w[13]) else $error("excite differs from word");
	select_copy_a:
	assert property (data_select_out == w[5:0]) else $error("select differs from word");
	forward_run_start_a:
	assert property ($past(st) == 3'h0 && st == 3'h1 |-> w[9] && excite_out
		&& run_speed_out == (data_select_out == 6'h01 ? speed_of_data_one_out : 32'h0))
		else $error("bad continuous start");
	run_edge_a:
	assert property ($past(st) == 3'h0 && st == 3'h1 |-> !$past(w[9]))
		else $error("start without run bit change");
	decel_begin_a:
	assert property ($past(st) == 3'h1 && st == 3'h2 |-> !w[9]) else $error("bad decel");
	decel_end_a:
	assert property (st == 3'h2 && decel_done_in |=> st == 3'h0) else $error("decel stuck");
	home_start_a:
	assert property ($past(st) == 3'h0 && st == 3'h3 |-> w[11] && excite_out)
		else $error("bad home start");
	home_hold_a:
	assert property (st == 3'h3 && !home_done_in && !reply_ok_out |=> st == 3'h3)
		else $error("homing dropped");
	pos_start_a:
	assert property ($past(st) == 3'h0 && st == 3'h4 |-> w[8] && excite_out)
		else $error("bad positioning start");
endmodule
bind mcs_slave mcs_slave_assertions u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
	.rx_end_in(rx_end_in), .rx_crc_ok_in(rx_crc_ok_in), .decel_done_in(decel_done_in),
	.home_done_in(home_done_in), .reply_ok_out(reply_ok_out), .excite_out(excite_out),
	.motion_state_out(motion_state_out), .run_speed_out(run_speed_out),
	.data_select_out(data_select_out), .motion_command_word_out(motion_command_word_out),
	.speed_of_data_one_out(speed_of_data_one_out));

// File: bench/mcs_slave_tb.sv
/* self-checking bench of the motion command register slave.
   assumes the master model and the bound checker. */
`timescale 1ns/1ps
module mcs_slave_tb;
	reg         core_clk_in = 1'b0;
	reg         rst_in = 1'b1;
	reg         dd = 1'b0, hd = 1'b0, pd = 1'b0;
	wire [7:0]  rxd, func;
	wire        rxv, rxe, rxc, rok, rerr, exc;
	wire [2:0]  st;
	wire [5:0]  sel;
	wire [15:0] word;
	wire [31:0] run, spd;
	integer     bad_count = 0, checks_done = 0, i;
	reg  [31:0] seed = 32'h1f1765e2, e_spd = 0;
	reg  [15:0] e_cmd = 0;
	reg  [2:0]  e_st = 0;
	always #4 core_clk_in = ~core_clk_in;
	mcs_master_model master (.core_clk_in(core_clk_in), .rx_data_out(rxd),
		.rx_valid_out(rxv), .rx_end_out(rxe), .rx_crc_ok_out(rxc));
	mcs_slave dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .rx_data_in(rxd),
		.rx_valid_in(rxv), .rx_end_in(rxe), .rx_crc_ok_in(rxc), .decel_done_in(dd),
		.home_done_in(hd), .pos_done_in(pd), .reply_ok_out(rok), .reply_err_out(rerr),
		.reply_func_out(func), .excite_out(exc), .motion_state_out(st), .run_speed_out(run),
		.data_select_out(sel), .motion_command_word_out(word), .speed_of_data_one_out(spd));
	function [31:0] xs(input [31:0] x);
		xs = x ^ (x << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task print_verdict;
		begin
			if (bad_count == 0 && checks_done > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task settle(input ok, input err);
		begin
			// reply pulse stands only until the edge after the frame end
			chk(rok, ok);
			chk(rerr, err);
			@(negedge core_clk_in);
			chk(word, e_cmd);
			chk(exc, e_cmd[13]);
			chk(sel, e_cmd[5:0]);
			chk(spd, e_spd);
			chk(st, e_st);
		end
	endtask
	task model(input [15:0] v);
		begin
			if (!v[13]) e_st = 0;
			else if (e_st == 0 && v[9] && !e_cmd[9]) e_st = 1;
			else if (e_st == 0 && v[11] && !e_cmd[11]) e_st = 3;
			else if (e_st == 0 && v[8] && !e_cmd[8]) e_st = 4;
			else if (e_st == 1 && !v[9]) e_st = 2;
			e_cmd = v;
		end
	endtask
	task wcmd(input [15:0] v);
		begin
			master.send06(8'h01, 16'h001e, v, 1'b1);
			model(v);
			settle(1'b1, 1'b0);
			chk(func, 8'h06);
		end
	endtask
	task fin;
		begin
			@(negedge core_clk_in);
			{dd, hd, pd} = {e_st == 2, e_st == 3, e_st == 4};
			@(negedge core_clk_in);
			{dd, hd, pd} = 3'h0;
			e_st = 0;
			@(negedge core_clk_in);
			chk(st, e_st);
		end
	endtask
	initial begin
		#100000;
		bad_count = bad_count + 1;
		print_verdict;
	end
	initial begin
		repeat (12) @(negedge core_clk_in);
		rst_in = 1'b0;
		wcmd(16'h2000);
		master.send10(16'h0502, 32'h0000_1388);
		e_spd = 32'h0000_1388;
		settle(1'b1, 1'b0);
		chk(func, 8'h10);
		wcmd(16'h2201);
		chk(run, 32'h0000_1388);
		wcmd(16'h2001);
		fin;
		wcmd(16'h2800);
		wcmd(16'h2000);
		fin;
		wcmd(16'h2101);
		fin;
		master.send06(8'h01, 16'h001e, 16'h0000, 1'b0);
		settle(1'b0, 1'b0);
		master.send06(8'h07, 16'h001e, 16'h0000, 1'b1);
		settle(1'b0, 1'b0);
		master.send06(8'h01, 16'h0100, 16'h0000, 1'b1);
		settle(1'b0, 1'b1);
		// register count other than 2 is refused
		master.frame({8'h01, 8'h10, 16'h0502, 16'h0003, 8'h04, 32'h0}, 11, 1'b1);
		settle(1'b0, 1'b1);
		chk(func, 8'h10);
		for (i = 0; i < 6; i = i + 1) begin
			seed = xs(seed);
			master.send10(16'h0502, seed);
			e_spd = seed;
			settle(1'b1, 1'b0);
			master.send06(8'h01, 16'h0503, ~seed[15:0], 1'b1);
			e_spd[15:0] = ~seed[15:0];
			settle(1'b1, 1'b0);
			wcmd(16'h2000);
			wcmd(seed[31:16] & 16'h0b3f | 16'h2000);
			if (e_st != 0) chk(run, (e_cmd[5:0] == 6'h01) ? e_spd : 32'h0);
			wcmd(16'h0000);
		end
		// reset again with motion idle after the loop
		@(negedge core_clk_in);
		rst_in = 1'b1;
		@(negedge core_clk_in);
		chk({st, exc, sel, word}, 32'h0);
		chk(spd, 32'h0);
		chk(run, 32'h0);
		rst_in = 1'b0;
		e_cmd = 16'h0000;
		e_spd = 32'h0;
		e_st = 3'h0;
		master.send06(8'h00, 16'h001e, 16'h2000, 1'b1);
		model(16'h2000);
		settle(1'b0, 1'b0);
		print_verdict;
	end
endmodule

// File: core/mcs_bit_edge.v
/*
 * rising and falling change detector for one held command bit.
 * assumes the level comes from a register on the same clock.
 */
`timescale 1ns/1ps
module mcs_bit_edge (
	// clock and reset
	input  wire core_clk_in,
	input  wire rst_in,
	// level and its changes
	input  wire level_in,
	output wire rise_out,
	output wire fall_out
);
	reg prev_ff;

	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= level_in;
		end
	end

	assign rise_out = level_in & ~prev_ff;
	assign fall_out = ~level_in & prev_ff;
endmodule

// File: core/mcs_defines.vh
/*
 * constants of the motion command register slave: register addresses,
 * function codes, command bit positions, reset values and frame lengths.
 * assumes inclusion by bare name from the design files.
 */
`ifndef MCS_DEFINES_VH
`define MCS_DEFINES_VH

// register addresses
`define MCS_CMD_ADDR      16'h001e
`define MCS_SPD_ADDR      16'h0502
`define MCS_SPD_ADDR_LO   16'h0503

// function codes and multi-write framing
`define MCS_FN_WRITE_ONE  8'h06
`define MCS_FN_WRITE_MULT 8'h10
`define MCS_MULT_COUNT    16'h0002
`define MCS_MULT_BYTES    8'h04
`define MCS_BCAST_ADDR    8'h00

// frame lengths in bytes, crc excluded
`define MCS_LEN_ONE       4'h6
`define MCS_LEN_MULT      4'hb
`define MCS_BUF_DEPTH     11

// command word bit positions
`define MCS_BIT_EXCITE    13
`define MCS_BIT_HOME      11
`define MCS_BIT_FORWARD_RUN 9
`define MCS_BIT_START     8
`define MCS_SEL_MSB       5
`define MCS_SEL_DATA_ONE  6'h01

// reset values
`define MCS_CMD_RST       16'h0000
`define MCS_SPD_RST       32'h0000_0000

// motion states
`define MCS_ST_IDLE       3'h0
`define MCS_ST_CONT       3'h1
`define MCS_ST_DECEL      3'h2
`define MCS_ST_HOME       3'h3
`define MCS_ST_POS        3'h4

`endif

// File: core/mcs_slave.v
/*
 * motion command register slave: takes checked rtu frame bytes, applies
 * single and multiple register writes to the command word and the speed
 * of data one, and sequences continuous, homing and positioning moves.
 * assumes framing, silent interval and crc are checked upstream on the
 * same clock, and the drive reports the end of each move with a pulse.
 */
// Summary of operation
// - Command word sits at 001Eh, set by function 06h, and bit 2000h holds excitation on.
// - Command bits 13, 11, 9 and 8 are flags and bits 5-0 select the data, so 2201h means excite, forward run, data one.
// - A rising forward run bit with excitation on starts forward continuous run at the speed of data one if data one is selected, else at zero speed.
// - Speed of data one is 32 bits at 0502h and 0503h, upper word first.
// - A function 10h write with count 2 and byte count 4 loads the speed entry.
// - A falling forward run bit during continuous run gives a deceleration stop.
// - A rising home bit with excitation on starts the return to home.
// - A rising start bit with excitation on starts positioning of the selected data.
`timescale 1ns/1ps
`include "mcs_defines.vh"
module mcs_slave #(
	parameter [7:0] SLAVE_ADDR = 8'h01
) (
	// clock and reset
	input  wire        core_clk_in,
	input  wire        rst_in,
	// frame bytes from the rtu receiver
	input  wire [7:0]  rx_data_in,
	input  wire        rx_valid_in,
	input  wire        rx_end_in,
	input  wire        rx_crc_ok_in,
	// move completion from the drive
	input  wire        decel_done_in,
	input  wire        home_done_in,
	input  wire        pos_done_in,
	// reply strobes to the transmitter
	output reg         reply_ok_out,
	output reg         reply_err_out,
	output reg  [7:0]  reply_func_out,
	// drive control
	output reg         excite_out,
	output reg  [2:0]  motion_state_out,
	output reg  [31:0] run_speed_out,
	output reg  [5:0]  data_select_out,
	// register contents
	output reg  [15:0] motion_command_word_out,
	output reg  [31:0] speed_of_data_one_out
);
	reg  [7:0]  buf_ff [0:`MCS_BUF_DEPTH-1];
	reg  [3:0]  cnt_ff;
	reg         ovf_ff;
	reg  [15:0] cmd_ff;
	reg  [31:0] spd_ff;
	reg  [2:0]  st_ff;
	reg  [2:0]  nxt_st;
	integer     i;

	wire [7:0]  func     = buf_ff[1];
	wire [15:0] reg_addr = {buf_ff[2], buf_ff[3]};
	wire [15:0] wr_val   = {buf_ff[4], buf_ff[5]};
	wire        addr_hit = (buf_ff[0] == SLAVE_ADDR) || (buf_ff[0] == `MCS_BCAST_ADDR);
	wire        bcast    = (buf_ff[0] == `MCS_BCAST_ADDR);
	wire        take     = rx_end_in & rx_crc_ok_in & ~ovf_ff & addr_hit;
	wire        one_ok   = (func == `MCS_FN_WRITE_ONE) && (cnt_ff == `MCS_LEN_ONE);
	wire        mult_ok  = (func == `MCS_FN_WRITE_MULT) && (cnt_ff == `MCS_LEN_MULT) &&
		(wr_val == `MCS_MULT_COUNT) && (buf_ff[6] == `MCS_MULT_BYTES);
	wire        hit_cmd  = one_ok && (reg_addr == `MCS_CMD_ADDR);
	wire        hit_shi  = one_ok && (reg_addr == `MCS_SPD_ADDR);
	wire        hit_slo  = one_ok && (reg_addr == `MCS_SPD_ADDR_LO);
	wire        hit_mult = mult_ok && (reg_addr == `MCS_SPD_ADDR);
	wire        hit_any  = hit_cmd | hit_shi | hit_slo | hit_mult;

	wire        excite   = cmd_ff[`MCS_BIT_EXCITE];
	wire [5:0]  sel      = cmd_ff[`MCS_SEL_MSB:0];
	wire        forward_run_rise;
	wire        forward_run_fall;
	wire        home_rise;
	wire        start_rise;

	// frame byte capture
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_ff <= 4'h0;
			ovf_ff <= 1'b0;
			for (i = 0; i < `MCS_BUF_DEPTH; i = i + 1) begin
				buf_ff[i] <= 8'h00;
			end
		end else if (rx_end_in) begin
			cnt_ff <= 4'h0;
			ovf_ff <= 1'b0;
		end else if (rx_valid_in) begin
			if (cnt_ff == `MCS_LEN_MULT) begin
				ovf_ff <= 1'b1;
			end else begin
				buf_ff[cnt_ff] <= rx_data_in;
				cnt_ff         <= cnt_ff + 4'h1;
			end
		end
	end

	// register writes and replies
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_ff         <= `MCS_CMD_RST;
			spd_ff         <= `MCS_SPD_RST;
			reply_ok_out   <= 1'b0;
			reply_err_out  <= 1'b0;
			reply_func_out <= 8'h00;
		end else begin
			reply_ok_out  <= take & hit_any & ~bcast;
			reply_err_out <= take & ~hit_any & ~bcast;
			if (take) begin
				reply_func_out <= func;
			end
			if (take && hit_cmd) begin
				cmd_ff <= wr_val;
			end
			if (take && hit_shi) begin
				spd_ff[31:16] <= wr_val;
			end
			if (take && hit_slo) begin
				spd_ff[15:0] <= wr_val;
			end
			if (take && hit_mult) begin
				spd_ff <= {buf_ff[7], buf_ff[8], buf_ff[9], buf_ff[10]};
			end
		end
	end

	// changes of run, home and start bits
	mcs_bit_edge u_forward_run_edge (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.level_in    (cmd_ff[`MCS_BIT_FORWARD_RUN]),
		.rise_out    (forward_run_rise),
		.fall_out    (forward_run_fall)
	);

	mcs_bit_edge u_home_edge (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.level_in    (cmd_ff[`MCS_BIT_HOME]),
		.rise_out    (home_rise),
		.fall_out    ()
	);

	mcs_bit_edge u_start_edge (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.level_in    (cmd_ff[`MCS_BIT_START]),
		.rise_out    (start_rise),
		.fall_out    ()
	);

	// motion sequencing
	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			`MCS_ST_IDLE: begin
				if (excite && forward_run_rise) begin
					nxt_st = `MCS_ST_CONT;
				end else if (excite && home_rise) begin
					nxt_st = `MCS_ST_HOME;
				end else if (excite && start_rise) begin
					nxt_st = `MCS_ST_POS;
				end
			end
			`MCS_ST_CONT: begin
				if (forward_run_fall) begin
					nxt_st = `MCS_ST_DECEL;
				end
			end
			`MCS_ST_DECEL: begin
				if (decel_done_in) begin
					nxt_st = `MCS_ST_IDLE;
				end
			end
			`MCS_ST_HOME: begin
				// home bit not needed to continue
				if (home_done_in) begin
					nxt_st = `MCS_ST_IDLE;
				end
			end
			`MCS_ST_POS: begin
				if (pos_done_in) begin
					nxt_st = `MCS_ST_IDLE;
				end
			end
			default: begin
				nxt_st = `MCS_ST_IDLE;
			end
		endcase
		if (!excite) begin
			nxt_st = `MCS_ST_IDLE;
		end
	end

	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_ff                   <= `MCS_ST_IDLE;
			excite_out              <= 1'b0;
			motion_state_out        <= `MCS_ST_IDLE;
			run_speed_out           <= `MCS_SPD_RST;
			data_select_out         <= 6'h00;
			motion_command_word_out <= `MCS_CMD_RST;
			speed_of_data_one_out   <= `MCS_SPD_RST;
		end else begin
			st_ff                   <= nxt_st;
			motion_state_out        <= nxt_st;
			excite_out              <= excite;
			data_select_out         <= sel;
			motion_command_word_out <= cmd_ff;
			speed_of_data_one_out   <= spd_ff;
			// speed of data one at start if data one is selected, else zero
			if (st_ff == `MCS_ST_IDLE && nxt_st != `MCS_ST_IDLE) begin
				run_speed_out <= (sel == `MCS_SEL_DATA_ONE) ? spd_ff : `MCS_SPD_RST;
			end
		end
	end
endmodule
